// >>> common/boost_seq_pkg.sv
package boost_seq_pkg;

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS         = 1000;
    localparam int US_DIV        = US_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Durations, in microseconds
    // ------------------------------------------------------------
    localparam int LIN_US        = 560;
    localparam int SS_HALF_US    = 128;
    localparam int SS_SECOND_US  = 384;
    localparam int ILIM_US       = 50;
    localparam int FIRST_RTRY_US = 5200;
    localparam int RETRY_US      = 5000;
    localparam int STAT_PULSE_US = 128;
    localparam int KEEPALIVE_US  = 32000000;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL0 = 8'h00;
    localparam logic [7:0] ADDR_CONTROL1 = 8'h01;
    localparam logic [7:0] ADDR_AUXCTRL  = 8'h05;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C0_KEEPALIVE_RST = 7;
    localparam int C0_PIN_LEVEL     = 7;
    localparam int C0_BOOST_ACTIVE  = 3;
    localparam int C1_HIZ_REQ       = 1;
    localparam int C1_SW_BOOST      = 0;
    localparam int A5_AUX_DISABLE   = 6;
    localparam int A5_PIN_BOOST_EN  = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_SW_BOOST   = 1'b0;
    localparam logic RST_HIZ        = 1'b0;
    localparam logic RST_PIN_EN     = 1'b0;
    localparam logic RST_AUX_DIS    = 1'b0;

    // ------------------------------------------------------------
    // Fault codes
    // ------------------------------------------------------------
    localparam logic [2:0] FLT_NONE    = 3'h0;
    localparam logic [2:0] FLT_OVP     = 3'h1;
    localparam logic [2:0] FLT_STARTUP = 3'h2;
    localparam logic [2:0] FLT_UVLO    = 3'h3;
    localparam logic [2:0] FLT_THERMAL = 3'h5;
    localparam logic [2:0] FLT_TIMER   = 3'h6;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LINEAR,
        ST_SOFTSTART,
        ST_RUN,
        ST_FAULT
    } boost_state_e;

endpackage

// >>> design/boost_startup_fault_sequencer.sv
`timescale 1ns/1ps
module boost_startup_fault_sequencer
    import boost_seq_pkg::*;
#(
    parameter int P_LIN_US        = LIN_US,
    parameter int P_SS_HALF_US    = SS_HALF_US,
    parameter int P_SS_SECOND_US  = SS_SECOND_US,
    parameter int P_FIRST_RTRY_US = FIRST_RTRY_US,
    parameter int P_RETRY_US      = RETRY_US,
    parameter int P_KEEPALIVE_US  = KEEPALIVE_US
) (
    input  wire logic       i_sys_clk,              // 125 MHz clock
    input  wire logic       i_resetn,               // Power-on reset
    input  wire logic [7:0] i_reg_addr,             // Register address
    input  wire logic       i_reg_wr,               // Write strobe
    input  wire logic [7:0] i_reg_wdata,            // Write data
    input  wire logic       i_reg_rd,               // Read strobe
    output logic      [7:0] o_reg_rdata,            // Read data
    input  wire logic       i_boost_request_pin,    // Pin, active high
    input  wire logic       i_bat_above_uvlo,       // Battery over UVLO
    input  wire logic       i_mid_rail_ready,       // Mid rail near battery
    input  wire logic       i_out_near_target,      // Output over 95 pct
    input  wire logic       i_fb_above_ref,         // Feedback over ref
    input  wire logic       i_current_limit,        // Peak limit active
    input  wire logic       i_out_overvoltage,      // Output overvoltage
    input  wire logic       i_thermal_shutdown,     // Die over limit
    input  wire logic       i_mid_above_bat,        // Mid rail over battery
    input  wire logic       i_termination_comparator, // Status bit 7
    input  wire logic       i_battery_comparator,   // Status bit 6
    input  wire logic       i_linear_charging_active, // Status bit 5
    input  wire logic       i_die_hot,              // Status bit 4
    input  wire logic       i_charge_loop_not_in_control, // Status bit 3
    input  wire logic       i_bus_limit_inactive,   // Status bit 2
    input  wire logic       i_input_supply_valid,   // Status bit 1
    input  wire logic       i_constant_voltage_flag, // Status bit 0
    output logic            o_linear_precharge,     // Precharge source on
    output logic            o_switch_enable,        // Boost switch allowed
    output logic            o_full_current_limit,   // 100 pct peak limit
    output logic            o_loop_closed,          // Regulation loop on
    output logic            o_power_stage_hiz,      // Power stage off
    output logic            o_aux_enable,           // Aux regulator on
    output logic            o_status_pulse,         // Fault pulse
    output logic            o_boost_active          // Boosting
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        boost_state_e st;
        logic [6:0]   div;
        logic [15:0]  dur;
        logic [24:0]  keep;
        logic [7:0]   pulse;
        logic [2:0]   fault;
        logic         sw_req;
        logic         hz;
        logic         pin_en;
        logic         aux_dis;
        logic         retried;
        logic [7:0]   rdata;
    } state_s;

    state_s s;
    state_s next_s;

    localparam logic [6:0]  DIV_LAST  = 7'(US_DIV - 1);
    localparam logic [15:0] LIN_T     = 16'(P_LIN_US);
    localparam logic [15:0] SS_HALF_T = 16'(P_SS_HALF_US);
    localparam logic [15:0] SS_END_T  = 16'(P_SS_HALF_US + P_SS_SECOND_US);
    localparam logic [15:0] ILIM_T    = 16'(ILIM_US);
    localparam logic [15:0] RTRY1_T   = 16'(P_FIRST_RTRY_US);
    localparam logic [15:0] RTRY_T    = 16'(P_RETRY_US);
    localparam logic [24:0] KEEP_T    = 25'(P_KEEPALIVE_US);
    localparam logic [7:0]  PULSE_T   = 8'(STAT_PULSE_US);

    function automatic logic is_active(input boost_state_e st);
        is_active = (st == ST_LINEAR) || (st == ST_SOFTSTART)
                 || (st == ST_RUN);
    endfunction

    logic       tick;
    logic       pin_path;
    logic       boost_en;
    logic       active;
    logic [7:0] status_live;

    assign tick     = (s.div == DIV_LAST);
    assign pin_path = s.pin_en & i_boost_request_pin;
    assign boost_en = pin_path | (~s.hz & s.sw_req);
    assign active   = is_active(s.st);

    // Raw comparator levels, no filtering
    assign status_live = {i_termination_comparator,
                          i_battery_comparator,
                          i_linear_charging_active,
                          i_die_hot,
                          i_charge_loop_not_in_control,
                          i_bus_limit_inactive,
                          i_input_supply_valid,
                          i_constant_voltage_flag};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0]   fcode;
        boost_state_e nst;
        fcode  = FLT_NONE;
        next_s = s;
        nst    = s.st;
        next_s.div = tick ? 7'h00 : s.div + 7'h01;

        // --------
        // Register writes
        // --------
        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_CONTROL1: begin
                    next_s.hz     = i_reg_wdata[C1_HIZ_REQ];
                    next_s.sw_req = i_reg_wdata[C1_SW_BOOST];
                end
                ADDR_AUXCTRL: begin
                    next_s.aux_dis = i_reg_wdata[A5_AUX_DISABLE];
                    next_s.pin_en  = i_reg_wdata[A5_PIN_BOOST_EN];
                end
                default: begin
                end
            endcase
        end

        // --------
        // Register reads, captured into a flop
        // --------
        next_s.rdata = s.rdata;
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_CONTROL0: begin
                    next_s.rdata = 8'h00;
                    next_s.rdata[C0_PIN_LEVEL]    = i_boost_request_pin;
                    next_s.rdata[C0_BOOST_ACTIVE] = active;
                    next_s.rdata[2:0]             = s.fault;
                    next_s.fault = FLT_NONE;
                end
                ADDR_CONTROL1: begin
                    next_s.rdata = {6'h00, s.hz, s.sw_req};
                end
                ADDR_AUXCTRL: begin
                    next_s.rdata = 8'h00;
                    next_s.rdata[A5_AUX_DISABLE]  = s.aux_dis;
                    next_s.rdata[A5_PIN_BOOST_EN] = s.pin_en;
                end
                ADDR_STATUS: begin
                    next_s.rdata = status_live;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        // --------
        // Keep-alive runs only while boosting
        // --------
        if (!active || (i_reg_wr && i_reg_addr == ADDR_CONTROL0
                        && i_reg_wdata[C0_KEEPALIVE_RST])) begin
            next_s.keep = 25'h0000000;
        end else if (tick && s.keep != KEEP_T) begin
            next_s.keep = s.keep + 25'h0000001;
        end

        // --------
        // Sequencer
        // --------
        case (s.st)
            ST_IDLE: begin
                if (!pin_path) begin
                    next_s.retried = 1'b0;
                end
                if (boost_en) begin
                    if (i_bat_above_uvlo) begin
                        nst = ST_LINEAR;
                    end else begin
                        fcode = FLT_UVLO;
                    end
                end
            end
            ST_LINEAR: begin
                if (i_mid_rail_ready) begin
                    nst = ST_SOFTSTART;
                end else if (s.dur >= LIN_T) begin
                    fcode = FLT_STARTUP;
                end
            end
            ST_SOFTSTART: begin
                if (i_out_near_target) begin
                    nst = ST_RUN;
                    // Good start rearms the long delay
                    next_s.retried = 1'b0;
                end else if (s.dur >= SS_END_T) begin
                    fcode = FLT_STARTUP;
                end
            end
            ST_RUN: begin
                if (s.dur > ILIM_T) begin
                    fcode = FLT_STARTUP;
                end
            end
            ST_FAULT: begin
                if (!pin_path) begin
                    next_s.retried = 1'b0;
                    if (boost_en) begin
                        nst = ST_LINEAR;
                    end else begin
                        nst = ST_IDLE;
                    end
                end else if (s.dur >= (s.retried ? RTRY_T : RTRY1_T)) begin
                    nst = ST_LINEAR;
                    next_s.retried = 1'b1;
                end
            end
            default: begin
                nst = ST_IDLE;
            end
        endcase

        // --------
        // Hazard faults during boost, highest priority last wins
        // --------
        if (active) begin
            if (!boost_en) begin
                nst = ST_IDLE;
                next_s.sw_req = 1'b0;
            end
            if (!i_bat_above_uvlo) begin
                fcode = FLT_UVLO;
            end
            if (i_out_overvoltage) begin
                fcode = FLT_OVP;
            end
            if (i_thermal_shutdown) begin
                fcode = FLT_THERMAL;
            end
            if (s.keep == KEEP_T) begin
                fcode = FLT_TIMER;
                next_s.hz      = RST_HIZ;
                next_s.pin_en  = RST_PIN_EN;
                next_s.aux_dis = RST_AUX_DIS;
            end
        end

        // --------
        // Only the listed codes reach the field
        // --------
        if (fcode != FLT_NONE) begin
            nst            = ST_FAULT;
            next_s.fault   = fcode;
            next_s.sw_req  = RST_SW_BOOST;
            next_s.pulse   = PULSE_T;
            next_s.keep    = 25'h0000000;
        end else if (tick && s.pulse != 8'h00) begin
            next_s.pulse = s.pulse - 8'h01;
        end

        // --------
        // Run state counts consecutive limit time only
        // --------
        if (nst != s.st) begin
            next_s.dur = 16'h0000;
        end else if (s.st == ST_RUN && !i_current_limit) begin
            next_s.dur = 16'h0000;
        end else if (tick && s.dur != 16'hFFFF) begin
            next_s.dur = s.dur + 16'h0001;
        end
        next_s.st = nst;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s.st      <= ST_IDLE;
            s.div     <= 7'h00;
            s.dur     <= 16'h0000;
            s.keep    <= 25'h0000000;
            s.pulse   <= 8'h00;
            s.fault   <= FLT_NONE;
            s.sw_req  <= RST_SW_BOOST;
            s.hz      <= RST_HIZ;
            s.pin_en  <= RST_PIN_EN;
            s.aux_dis <= RST_AUX_DIS;
            s.retried <= 1'b0;
            s.rdata   <= 8'h00;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_reg_rdata        = s.rdata;
    assign o_linear_precharge = (s.st == ST_LINEAR);
    // Skipping pulses above the reference keeps the output from pumping
    assign o_switch_enable    = (s.st == ST_SOFTSTART)
                             || (s.st == ST_RUN && !i_fb_above_ref);
    assign o_full_current_limit = (s.st == ST_RUN)
                             || (s.st == ST_SOFTSTART
                                 && s.dur >= SS_HALF_T);
    assign o_loop_closed      = (s.st == ST_RUN);
    assign o_power_stage_hiz  = !active;
    assign o_aux_enable       = i_mid_above_bat && !active
                             && !s.hz && !s.aux_dis;
    assign o_status_pulse     = (s.pulse != 8'h00);
    assign o_boost_active     = active;

endmodule

// >>> tb/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
    input  wire logic       i_sys_clk,    // Clock
    input  wire logic       i_resetn,     // Reset
    input  wire logic       i_precharge,  // Linear source on
    input  wire logic       i_switching,  // Switch allowed
    input  wire logic       i_full_limit, // Full peak limit
    input  wire logic       i_hiz,        // Stage off
    input  wire logic       i_pre_ok,     // Rail can rise
    input  wire logic [1:0] i_ss_mode,    // 0 stuck, 1 fast, 2 slow
    output logic            o_mid_ready,  // Rail near battery
    output logic            o_near        // Output near target
);
    logic [9:0] pre_cnt;
    logic [9:0] sw_cnt;
    // Rail collapses as soon as the source stops, so no stale ready
    assign o_mid_ready = i_pre_ok && pre_cnt > 10'h0C8;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pre_cnt <= 10'h000;
            sw_cnt  <= 10'h000;
            o_near  <= 1'b0;
        end else begin
            pre_cnt <= i_precharge ? pre_cnt + 10'(~&pre_cnt) : 10'h000;
            if (i_hiz) begin
                sw_cnt <= 10'h000;
                o_near <= 1'b0;
            end else begin
                if (i_switching && !(&sw_cnt)) begin
                    sw_cnt <= sw_cnt + 10'h001;
                end
                // Slow mode only reaches target with the full limit
                if ((i_ss_mode == 2'h1 && sw_cnt > 10'h12C) ||
                    (i_ss_mode == 2'h2 && i_full_limit)) begin
                    o_near <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> tb/boost_seq_asserts.sv
`timescale 1ns/1ps
module boost_seq_asserts
    import boost_seq_pkg::*;
#(
    parameter int P_LIN_US       = LIN_US,
    parameter int P_SS_HALF_US   = SS_HALF_US,
    parameter int P_SS_SECOND_US = SS_SECOND_US
) (
    input wire logic       i_sys_clk,            // Clock
    input wire logic       i_resetn,             // Reset
    input wire logic [7:0] i_reg_addr,           // Address
    input wire logic       i_reg_rd,             // Read strobe
    input wire logic [7:0] o_reg_rdata,          // Read data
    input wire logic       i_mid_rail_ready,     // Rail ready
    input wire logic       i_out_near_target,    // Output near
    input wire logic       i_fb_above_ref,       // Feedback high
    input wire logic       i_mid_above_bat,      // Rail over battery
    input wire logic       o_linear_precharge,   // Precharge
    input wire logic       o_switch_enable,      // Switch
    input wire logic       o_full_current_limit, // Full limit
    input wire logic       o_loop_closed,        // Run
    input wire logic       o_power_stage_hiz,    // Stage off
    input wire logic       o_aux_enable,         // Aux on
    input wire logic       o_status_pulse,       // Fault pulse
    input wire logic       o_boost_active        // Boosting
);
    logic        ss;
    logic [15:0] pre_cnt;
    logic [15:0] ss_cnt;
    assign ss = o_boost_active && !o_linear_precharge && !o_loop_closed;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pre_cnt <= 16'h0000;
            ss_cnt  <= 16'h0000;
        end else begin
            pre_cnt <= o_linear_precharge ? pre_cnt + 16'h0001 : 16'h0000;
            ss_cnt  <= ss ? ss_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_pre_done;
        o_linear_precharge && i_mid_rail_ready;
    endsequence
    sequence s_ss_done;
        ss && i_out_near_target;
    endsequence
    a_precharge_drive: assert property (o_linear_precharge |->
        o_boost_active && !o_switch_enable) else $error("precharge drive");
    a_hiz_vs_boost: assert property (o_power_stage_hiz != o_boost_active
        && !(o_power_stage_hiz && o_switch_enable)) else $error("stage state");
    a_pre_to_ss: assert property (s_pre_done |=> ss && o_switch_enable
        && !o_full_current_limit) else $error("soft-start entry");
    a_pre_timeout: assert property (pre_cnt <= (P_LIN_US + 1) * US_DIV)
        else $error("precharge too long");
    a_ss_half: assert property (ss && ss_cnt < (P_SS_HALF_US - 1) * US_DIV
        |-> !o_full_current_limit) else $error("early full limit");
    a_ss_full: assert property (ss && ss_cnt > (P_SS_HALF_US + 1) * US_DIV
        |-> o_full_current_limit) else $error("late full limit");
    a_ss_timeout: assert property (ss_cnt <=
        (P_SS_HALF_US + P_SS_SECOND_US + 1) * US_DIV) else $error("ss long");
    a_ss_to_run: assert property (s_ss_done |=> o_loop_closed
        || o_status_pulse) else $error("run entry");
    a_run_full: assert property (o_loop_closed |-> o_full_current_limit)
        else $error("run limit");
    a_run_hold_off: assert property (o_loop_closed && i_fb_above_ref
        |-> !o_switch_enable) else $error("switch on above ref");
    a_fault_pulse: assert property ($rose(o_status_pulse)
        |-> o_power_stage_hiz) else $error("pulse without stage off");
    a_aux_gate: assert property (o_aux_enable |->
        i_mid_above_bat && !o_boost_active) else $error("aux gate");
    a_code_legal: assert property ($past(i_reg_rd && i_reg_addr == 8'h00)
        |-> o_reg_rdata[2:0] != 3'h4 && o_reg_rdata[2:0] != 3'h7)
        else $error("illegal code");
endmodule
bind boost_startup_fault_sequencer boost_seq_asserts #(
    .P_LIN_US(P_LIN_US), .P_SS_HALF_US(P_SS_HALF_US),
    .P_SS_SECOND_US(P_SS_SECOND_US)
) i_asserts (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_mid_rail_ready(i_mid_rail_ready),
    .i_out_near_target(i_out_near_target),
    .i_fb_above_ref(i_fb_above_ref), .i_mid_above_bat(i_mid_above_bat),
    .o_linear_precharge(o_linear_precharge),
    .o_switch_enable(o_switch_enable),
    .o_full_current_limit(o_full_current_limit),
    .o_loop_closed(o_loop_closed), .o_power_stage_hiz(o_power_stage_hiz),
    .o_aux_enable(o_aux_enable), .o_status_pulse(o_status_pulse),
    .o_boost_active(o_boost_active)
);

// >>> tb/boost_startup_fault_sequencer_test.sv
`timescale 1ns/1ps
module boost_startup_fault_sequencer_test;
    import boost_seq_pkg::*;
    localparam int T = US_DIV;
    localparam int HALF = 4;
    localparam int SEC = 8;
    localparam int FIRST = 40;
    localparam int RTRY = 30;
    logic       i_sys_clk = 1'b0;
    logic       i_resetn = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic       i_reg_wr = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic       i_reg_rd = 1'b0;
    logic [7:0] o_reg_rdata;
    logic       pin = 1'b0, bat_ok = 1'b1, fb = 1'b0, ilim = 1'b0;
    logic       ovp = 1'b0, hot = 1'b0, mid_bat = 1'b1, pre_ok = 1'b1;
    logic [7:0] stat = 8'h00;
    logic [1:0] ss_mode = 2'h1;
    logic       rdy, near, pre, sw, full, loop, hiz, aux, pulse, act;
    logic [7:0] outs;
    logic [2:0] code [3] = '{3'h1, 3'h5, 3'h3};
    int         n_errors = 0;
    int         total_checks = 0;
    int         n;
    assign outs = {aux, sw, full, pre, loop, hiz, pulse, act};
    always #4 i_sys_clk = ~i_sys_clk;
    boost_startup_fault_sequencer #(.P_LIN_US(20), .P_SS_HALF_US(HALF),
        .P_SS_SECOND_US(SEC), .P_FIRST_RTRY_US(FIRST),
        .P_RETRY_US(RTRY), .P_KEEPALIVE_US(120)) i_dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_boost_request_pin(pin),
        .i_bat_above_uvlo(bat_ok), .i_mid_rail_ready(rdy),
        .i_out_near_target(near), .i_fb_above_ref(fb),
        .i_current_limit(ilim), .i_out_overvoltage(ovp),
        .i_thermal_shutdown(hot), .i_mid_above_bat(mid_bat),
        .i_termination_comparator(stat[7]), .i_battery_comparator(stat[6]),
        .i_linear_charging_active(stat[5]), .i_die_hot(stat[4]),
        .i_charge_loop_not_in_control(stat[3]),
        .i_bus_limit_inactive(stat[2]), .i_input_supply_valid(stat[1]),
        .i_constant_voltage_flag(stat[0]), .o_linear_precharge(pre),
        .o_switch_enable(sw), .o_full_current_limit(full),
        .o_loop_closed(loop), .o_power_stage_hiz(hiz), .o_aux_enable(aux),
        .o_status_pulse(pulse), .o_boost_active(act));
    power_stage_model i_stage (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_precharge(pre), .i_switching(sw), .i_full_limit(full),
        .i_hiz(hiz), .i_pre_ok(pre_ok), .i_ss_mode(ss_mode),
        .o_mid_ready(rdy), .o_near(near));
    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, e);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_sys_clk);
        chk($sformatf("reg_%h", a), e, o_reg_rdata);
        @(posedge i_sys_clk);
    endtask
    task automatic look(input int idx, input logic lv);
        @(negedge i_sys_clk);
        chk($sformatf("out_%0d", idx), 8'(lv), 8'(outs[idx]));
        @(posedge i_sys_clk);
    endtask
    // Bounded wait; a timeout shows up as a mismatch
    task automatic wt(input int idx, input logic lv, input int lim,
                      output int cnt);
        cnt = 0;
        @(negedge i_sys_clk);
        while (outs[idx] !== lv && cnt < lim) begin
            @(negedge i_sys_clk);
            cnt++;
        end
        chk($sformatf("wait_%0d", idx), 8'(lv), 8'(outs[idx]));
        @(posedge i_sys_clk);
    endtask
    task automatic results;
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #(95000 * 8);
        n_errors++;
        results();
    end
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        @(posedge i_sys_clk);
        rd(ADDR_CONTROL0, 8'h00);
        rd(ADDR_CONTROL1, 8'h00);
        rd(ADDR_AUXCTRL, 8'h00);
        rd(8'h03, 8'h00);
        wr(ADDR_STATUS, 8'hFF);
        stat <= 8'hA5;
        rd(ADDR_STATUS, 8'hA5);
        stat <= 8'h5A;
        rd(ADDR_STATUS, 8'h5A);
        wr(ADDR_AUXCTRL, 8'h40);
        wr(ADDR_CONTROL1, 8'h01);
        wt(3, 1'b1, 20 * T, n);
        rd(ADDR_CONTROL0, 8'h08);
        repeat (80 * T) @(posedge i_sys_clk);
        wr(ADDR_CONTROL0, 8'h80);
        repeat (70 * T) @(posedge i_sys_clk);
        look(0, 1'b1);
        wt(2, 1'b1, 80 * T, n);
        rd(ADDR_CONTROL0, 8'h06);
        rd(ADDR_AUXCTRL, 8'h00);
        rd(ADDR_CONTROL0, 8'h00);
        wr(ADDR_CONTROL1, 8'h01);
        wt(3, 1'b1, 20 * T, n);
        fb <= 1'b1;
        look(6, 1'b0);
        fb <= 1'b0;
        look(6, 1'b1);
        ilim <= 1'b1;
        wt(2, 1'b1, 60 * T, n);
        chk("ilim_time", 8'h01, 8'(n >= (ILIM_US - 1) * T));
        ilim <= 1'b0;
        rd(ADDR_CONTROL1, 8'h00);
        rd(ADDR_CONTROL0, 8'h02);
        repeat (50 * T) @(posedge i_sys_clk);
        look(0, 1'b0);
        pre_ok <= 1'b0;
        wr(ADDR_CONTROL1, 8'h01);
        look(4, 1'b1);
        wt(2, 1'b1, 30 * T, n);
        chk("pre_time", 8'h01, 8'(n >= 18 * T));
        rd(ADDR_CONTROL0, 8'h02);
        pre_ok <= 1'b1;
        ss_mode <= 2'h0;
        wr(ADDR_CONTROL1, 8'h01);
        wt(2, 1'b1, (HALF + SEC + 4) * T, n);
        chk("ss_time", 8'h01, 8'(n >= (HALF + SEC - 1) * T));
        rd(ADDR_CONTROL0, 8'h02);
        ss_mode <= 2'h2;
        wr(ADDR_CONTROL1, 8'h01);
        wt(6, 1'b1, 4 * T, n);
        look(5, 1'b0);
        wt(3, 1'b1, (HALF + 4) * T, n);
        chk("slow_time", 8'h01, 8'(n >= (HALF - 1) * T));
        wr(ADDR_CONTROL1, 8'h00);
        look(0, 1'b0);
        rd(ADDR_CONTROL0, 8'h00);
        ss_mode <= 2'h1;
        for (int i = 0; i < 3; i++) begin
            bat_ok <= (i != 2);
            wr(ADDR_CONTROL1, 8'h01);
            if (i < 2) begin
                wt(3, 1'b1, 20 * T, n);
                ovp <= (i == 0);
                hot <= (i == 1);
            end
            wt(2, 1'b1, 4 * T, n);
            look(1, 1'b1);
            rd(ADDR_CONTROL0, {5'h00, code[i]});
            ovp <= 1'b0;
            hot <= 1'b0;
        end
        bat_ok <= 1'b1;
        wt(1, 1'b0, (STAT_PULSE_US + 2) * T, n);
        chk("pulse_time", 8'h01, 8'(n >= (STAT_PULSE_US - 2) * T));
        ss_mode <= 2'h0;
        wr(ADDR_AUXCTRL, 8'h08);
        pin <= 1'b1;
        wt(2, 1'b0, 4 * T, n);
        wt(2, 1'b1, 20 * T, n);
        rd(ADDR_CONTROL0, 8'h82);
        wt(0, 1'b1, (FIRST + 3) * T, n);
        chk("first_retry", 8'h01, 8'(n >= (FIRST - 2) * T));
        wt(2, 1'b1, 20 * T, n);
        wt(0, 1'b1, (RTRY + 3) * T, n);
        chk("next_retry", 8'h01, 8'(n >= (RTRY - 2) * T));
        wt(2, 1'b1, 20 * T, n);
        wr(ADDR_AUXCTRL, 8'h00);
        repeat ((FIRST + 5) * T) @(posedge i_sys_clk);
        look(0, 1'b0);
        pin <= 1'b0;
        look(7, 1'b1);
        wr(ADDR_AUXCTRL, 8'h40);
        look(7, 1'b0);
        wr(ADDR_AUXCTRL, 8'h00);
        wr(ADDR_CONTROL1, 8'h02);
        rd(ADDR_STATUS, 8'h5A);
        look(7, 1'b0);
        wr(ADDR_CONTROL1, 8'h00);
        look(7, 1'b1);
        results();
    end
endmodule
